// file: uart_ctrl3_data.v
`timescale 1ns/1ps
`include "uart_slice_map.vh"
module uart_ctrl3_data
(
    input wire clk,
    input wire rst_b,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    output wire irq,
    input wire tx_pin_in,
    output wire tx_pin_out,
    output wire tx_pin_oe,
    input wire rx_pin,
    input wire parity_error_in
);
    // ****************************************
    // Register state.
    // ****************************************
    reg [7:0] serial_control_three;
    reg [7:0] mode_reg;
    reg [7:0] irq_status;
    reg [7:0] irq_mask;
    reg [8:0] tx_buffer;
    reg tx_full;
    reg [8:0] rx_buffer;
    reg rx_full;
    reg overrun_flag;
    reg noise_flag;
    reg framing_fault_flag;
    reg parity_fault_flag;
    reg status_seen;
    wire tx_busy;
    wire tx_done;
    wire tx_line;
    wire rx_done;
    wire [8:0] rx_word;
    wire rx_frame_err;
    wire rx_noise_err;
    wire [11:0] addr_w = paddr;
    wire access = psel && penable;
    wire wr = access && pwrite;
    wire rd = access && !pwrite;
    wire data_length_select = mode_reg[`MODE_NINE];
    wire loop_select = mode_reg[`MODE_LOOP];
    wire receiver_source_select = mode_reg[`MODE_RECEIVER_SOURCE_SELECT];
    wire single_wire = loop_select && receiver_source_select;
    wire tx_polarity_invert = serial_control_three[`C3_TX_POLARITY_INVERT];
    wire ninth_tx_bit = serial_control_three[`C3_TX9];
    wire tx_load = tx_full && !tx_busy;
    wire data_rd = rd && (addr_w == `ADDR_DATA);
    wire data_wr = wr && (addr_w == `ADDR_DATA);
    wire stat_rd = rd && (addr_w == `ADDR_STATUS);
    wire clear_step = data_rd && status_seen;
    wire mapped = (addr_w == `ADDR_CTRL3) || (addr_w == `ADDR_DATA) || (addr_w == `ADDR_MODE) ||
        (addr_w == `ADDR_STATUS) || (addr_w == `ADDR_IRQ_STAT) || (addr_w == `ADDR_IRQ_MASK);
    wire rx_into_core = single_wire ? tx_pin_in : (loop_select ? tx_line : rx_pin);
    wire [7:0] err_events;

    // Zero-wait slave; unmapped addresses answer with an error.
    assign pready = 1'b1;
    assign pslverr = access && !mapped;

    // ****************************************
    // Serial engine.
    // ****************************************
    uart_bit_core u_core
    (
        .clk(clk),
        .rst_b(rst_b),
        .nine_bit(data_length_select),
        .tx_load(tx_load),
        .tx_word(tx_buffer),
        .tx_busy(tx_busy),
        .tx_done(tx_done),
        .tx_line(tx_line),
        .rx_line(rx_into_core),
        .rx_done(rx_done),
        .rx_word(rx_word),
        .rx_frame_err(rx_frame_err),
        .rx_noise_err(rx_noise_err)
    );

    // Inversion covers idle and frame bits alike.
    assign tx_pin_out = tx_line ^ tx_polarity_invert;
    // Pin turns to an input only in single-wire mode with direction clear.
    assign tx_pin_oe = single_wire ? serial_control_three[`C3_SINGLE_WIRE_TX_DIRECTION] : 1'b1;

    // Control registers; the ninth receive bit is hardware-owned.
    always @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            serial_control_three <= `C3_RESET;
            mode_reg <= `MODE_RESET;
            irq_mask <= `IRQ_RESET;
        end
        else
        begin
            if (wr && (addr_w == `ADDR_CTRL3))
            begin
                serial_control_three[6:0] <= pwdata[6:0];
            end
            if (wr && (addr_w == `ADDR_MODE))
            begin
                mode_reg <= {5'h00, pwdata[2:0]};
            end
            if (wr && (addr_w == `ADDR_IRQ_MASK))
            begin
                irq_mask <= pwdata[7:0];
            end
            if (rx_done && (!rx_full || data_rd))
            begin
                serial_control_three[`C3_RX9] <= data_length_select & rx_word[8];
            end
        end
    end

    // Transmit buffer; ninth bit is sampled from control three at the data write, not at tx_load.
    always @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            tx_buffer <= 9'h000;
            tx_full <= 1'b0;
        end
        else
        begin
            if (data_wr)
            begin
                tx_buffer <= {ninth_tx_bit, pwdata[7:0]};
                tx_full <= 1'b1;
            end
            else if (tx_load)
            begin
                tx_full <= 1'b0;
            end
        end
    end

    // Receive buffer and error flags; any data read empties the buffer, status read then data read clears the flags.
    // A new event in the clearing cycle wins over the clear.
    always @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rx_buffer <= 9'h000;
            rx_full <= 1'b0;
            overrun_flag <= 1'b0;
            noise_flag <= 1'b0;
            framing_fault_flag <= 1'b0;
            parity_fault_flag <= 1'b0;
            status_seen <= 1'b0;
        end
        else
        begin
            if (stat_rd)
            begin
                status_seen <= 1'b1;
            end
            else if (data_rd)
            begin
                status_seen <= 1'b0;
            end
            if (clear_step)
            begin
                overrun_flag <= 1'b0;
                noise_flag <= 1'b0;
                framing_fault_flag <= 1'b0;
                parity_fault_flag <= 1'b0;
            end
            if (data_rd)
            begin
                rx_full <= 1'b0;
            end
            if (rx_done)
            begin
                if (rx_full && !data_rd)
                begin
                    overrun_flag <= 1'b1;
                end
                else
                begin
                    rx_buffer <= rx_word;
                    rx_full <= 1'b1;
                    noise_flag <= rx_noise_err;
                    framing_fault_flag <= rx_frame_err;
                    parity_fault_flag <= parity_error_in;
                end
            end
        end
    end

    // ****************************************
    // Interrupt status, reloaded from the current events by reading it.
    // ****************************************
    assign err_events[`ST_PF] = parity_fault_flag & serial_control_three[`C3_PARITY_IRQ_ENABLE];
    assign err_events[`ST_FE] = framing_fault_flag & serial_control_three[`C3_FRAMING_IRQ_ENABLE];
    assign err_events[`ST_NF] = noise_flag & serial_control_three[`C3_NOISE_IRQ_ENABLE];
    assign err_events[`ST_OR] = overrun_flag & serial_control_three[`C3_OVERRUN_IRQ_ENABLE];
    assign err_events[`IRQ_TXDONE] = tx_done;
    assign err_events[`IRQ_RXDONE] = rx_done;
    assign err_events[7:6] = 2'b00;

    // Sticky bits; a set in the read cycle survives the read clear.
    always @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            irq_status <= `IRQ_RESET;
        end
        else if (rd && (addr_w == `ADDR_IRQ_STAT))
        begin
            irq_status <= err_events;
        end
        else
        begin
            irq_status <= irq_status | err_events;
        end
    end

    assign irq = |(irq_status & irq_mask);

    // Read mux; the data port returns the receive buffer only.
    always @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            prdata <= 32'h00000000;
        end
        else if (psel && !penable && !pwrite)
        begin
            if (addr_w == `ADDR_CTRL3)
            begin
                prdata <= {24'h000000, serial_control_three};
            end
            else if (addr_w == `ADDR_DATA)
            begin
                prdata <= {24'h000000, rx_buffer[7:0]};
            end
            else if (addr_w == `ADDR_MODE)
            begin
                prdata <= {24'h000000, mode_reg};
            end
            else if (addr_w == `ADDR_STATUS)
            begin
                prdata <= {26'h0000000, !tx_full, rx_full, overrun_flag, noise_flag,
                    framing_fault_flag, parity_fault_flag};
            end
            else if (addr_w == `ADDR_IRQ_STAT)
            begin
                prdata <= {24'h000000, irq_status};
            end
            else if (addr_w == `ADDR_IRQ_MASK)
            begin
                prdata <= {24'h000000, irq_mask};
            end
            else
            begin
                prdata <= 32'h00000000;
            end
        end
    end
endmodule // uart_ctrl3_data

// file: uart_slice_map.vh
`ifndef UART_SLICE_MAP_VH
`define UART_SLICE_MAP_VH
// ****************************************
// Register byte addresses.
// ****************************************
`define ADDR_CTRL3 12'h000
`define ADDR_DATA 12'h004
`define ADDR_MODE 12'h008
`define ADDR_STATUS 12'h00C
`define ADDR_IRQ_STAT 12'h010
`define ADDR_IRQ_MASK 12'h014
// ****************************************
// Control three field positions.
// ****************************************
`define C3_RX9 7
`define C3_TX9 6
`define C3_SINGLE_WIRE_TX_DIRECTION 5
`define C3_TX_POLARITY_INVERT 4
`define C3_OVERRUN_IRQ_ENABLE 3
`define C3_NOISE_IRQ_ENABLE 2
`define C3_FRAMING_IRQ_ENABLE 1
`define C3_PARITY_IRQ_ENABLE 0
`define C3_RESET 8'h00
`define C3_WR_MASK 8'h7F
// ****************************************
// Mode register fields.
// ****************************************
`define MODE_NINE 0
`define MODE_LOOP 1
`define MODE_RECEIVER_SOURCE_SELECT 2
`define MODE_RESET 8'h00
// ****************************************
// Status and interrupt fields.
// ****************************************
`define ST_PF 0
`define ST_FE 1
`define ST_NF 2
`define ST_OR 3
`define ST_RDRF 4
`define ST_TDRE 5
`define IRQ_TXDONE 4
`define IRQ_RXDONE 5
`define IRQ_RESET 8'h00
// ****************************************
// Serial timing.
// ****************************************
`define CLK_MHZ 125
`define BAUD_KBPS 1000
`define BIT_CYCLES ((`CLK_MHZ * 1000) / `BAUD_KBPS)
`define NOISE_LEAD 16'h0008
`endif

// file: uart_bit_core.v
`timescale 1ns/1ps
`include "uart_slice_map.vh"
module uart_bit_core
(
    input wire clk,
    input wire rst_b,
    input wire nine_bit,
    input wire tx_load,
    input wire [8:0] tx_word,
    output reg tx_busy,
    output reg tx_done,
    output reg tx_line,
    input wire rx_line,
    output reg rx_done,
    output reg [8:0] rx_word,
    output reg rx_frame_err,
    output reg rx_noise_err
);
    // ****************************************
    // Bit-rate enable divider.
    // ****************************************
    localparam integer BIT_INT = `BIT_CYCLES - 1;
    localparam [15:0] BIT_MAX = BIT_INT[15:0];
    reg [15:0] tx_cnt;
    reg [15:0] rx_cnt;
    reg [10:0] tx_shift;
    reg [3:0] tx_bits;
    reg [3:0] rx_bits;
    reg rx_active;
    reg [9:0] rx_shift;
    reg s_a;
    reg s_b;
    reg rx_early;
    reg rx_noisy;
    wire [3:0] frame_bits = nine_bit ? 4'hB : 4'hA;

    // Transmitter: start bit, data LSB first, stop bit; idles high.
    always @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            tx_cnt <= 16'h0000;
            tx_shift <= 11'h7FF;
            tx_bits <= 4'h0;
            tx_busy <= 1'b0;
            tx_done <= 1'b0;
            tx_line <= 1'b1;
        end
        else
        begin
            tx_done <= 1'b0;
            if (!tx_busy)
            begin
                tx_line <= 1'b1;
                if (tx_load)
                begin
                    // Ninth bit dropped in eight-bit mode.
                    tx_shift <= nine_bit ? {1'b1, tx_word, 1'b0} : {2'b11, tx_word[7:0], 1'b0};
                    tx_bits <= frame_bits;
                    tx_busy <= 1'b1;
                    tx_cnt <= 16'h0000;
                end
            end
            else if (tx_cnt == 16'h0000)
            begin
                tx_line <= tx_shift[0];
                tx_shift <= {1'b1, tx_shift[10:1]};
                tx_cnt <= BIT_MAX;
                if (tx_bits == 4'h0)
                begin
                    tx_busy <= 1'b0;
                    tx_done <= 1'b1;
                end
                else
                begin
                    tx_bits <= tx_bits - 4'h1;
                end
            end
            else
            begin
                tx_cnt <= tx_cnt - 16'h0001;
            end
        end
    end

    // Receiver samples mid-bit; a level change between the early look and the sample counts as noise.
    // Two looks per bit are cheaper than a majority vote and still catch a mid-bit glitch.
    always @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            s_a <= 1'b1;
            s_b <= 1'b1;
            rx_cnt <= 16'h0000;
            rx_bits <= 4'h0;
            rx_active <= 1'b0;
            rx_shift <= 10'h000;
            rx_done <= 1'b0;
            rx_word <= 9'h000;
            rx_frame_err <= 1'b0;
            rx_noise_err <= 1'b0;
            rx_early <= 1'b1;
            rx_noisy <= 1'b0;
        end
        else
        begin
            s_a <= rx_line;
            s_b <= s_a;
            rx_done <= 1'b0;
            if (!rx_active)
            begin
                if (!s_b)
                begin
                    rx_active <= 1'b1;
                    rx_cnt <= {1'b0, BIT_MAX[15:1]};
                    rx_bits <= frame_bits - 4'h1;
                    rx_noisy <= 1'b0;
                end
            end
            else if (rx_cnt != 16'h0000)
            begin
                rx_cnt <= rx_cnt - 16'h0001;
                // Early look at the line, a few cycles before the mid-bit sample.
                if (rx_cnt == `NOISE_LEAD)
                begin
                    rx_early <= s_b;
                end
            end
            else
            begin
                rx_cnt <= BIT_MAX;
                rx_shift <= {s_b, rx_shift[9:1]};
                rx_noisy <= rx_noisy | (s_b != rx_early);
                if (rx_bits == (frame_bits - 4'h1) && s_b)
                begin
                    rx_active <= 1'b0;
                end
                else if (rx_bits == 4'h0)
                begin
                    rx_active <= 1'b0;
                    rx_done <= 1'b1;
                    rx_frame_err <= !s_b;
                    rx_noise_err <= rx_noisy | (s_b != rx_early);
                    rx_word <= nine_bit ? rx_shift[9:1] : {1'b0, rx_shift[9:2]};
                end
                else
                begin
                    rx_bits <= rx_bits - 4'h1;
                end
            end
        end
    end
endmodule // uart_bit_core

// file: uart_ctrl3_data_properties.sv
`timescale 1ns/1ps
`include "uart_slice_map.vh"
module uart_ctrl3_data_checker
(
    input wire clk,
    input wire rst_b,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire irq,
    input wire tx_pin_in,
    input wire tx_pin_out,
    input wire tx_pin_oe,
    input wire rx_pin,
    input wire parity_error_in
);
    // ****************************************
    // Shadow copies of the writable registers.
    // ****************************************
    reg [7:0] c3_sh;
    reg [7:0] mode_sh;
    reg [7:0] mask_sh;
    wire acc = psel && penable;
    wire rd_acc = acc && !pwrite;

    // Shadows follow completed writes so the rules can be judged from the ports alone.
    always @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            c3_sh <= 8'h00;
            mode_sh <= 8'h00;
            mask_sh <= 8'h00;
        end
        else if (acc && pwrite)
        begin
            if (paddr == `ADDR_CTRL3) c3_sh <= pwdata[7:0];
            if (paddr == `ADDR_MODE) mode_sh <= pwdata[7:0];
            if (paddr == `ADDR_IRQ_MASK) mask_sh <= pwdata[7:0];
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    // ****************************************
    // Assertions.
    // ****************************************
    a_ready_high: assert property (acc |-> pready)
        else $error("pready low in access phase");
    a_unmapped_refused: assert property (acc && paddr > `ADDR_IRQ_MASK |-> pslverr && (pwrite || prdata == 32'h0))
        else $error("unmapped access not refused");
    a_data_narrow: assert property (rd_acc && paddr == `ADDR_DATA |-> !pslverr && prdata[31:8] == 24'h0)
        else $error("data read wider than a byte");
    a_ctrl3_readback: assert property (rd_acc && paddr == `ADDR_CTRL3 |-> prdata[6:0] == c3_sh[6:0])
        else $error("control three readback differs");
    a_start_bit_hold: assert property ($fell(tx_pin_out) && !c3_sh[4] |-> !tx_pin_out [*8])
        else $error("low level on transmit pin too short");
    a_irq_needs_mask: assert property (mask_sh[5:0] == 6'h00 |-> !irq)
        else $error("irq high with all sources masked");
    a_irq_from_stat: assert property (rd_acc && paddr == `ADDR_IRQ_STAT && (prdata[5:0] & mask_sh[5:0]) != 6'h00 |-> irq)
        else $error("pending unmasked cause without irq");
    a_pin_direction: assert property (mode_sh[`MODE_LOOP] && mode_sh[`MODE_RECEIVER_SOURCE_SELECT] |-> tx_pin_oe == c3_sh[5])
        else $error("single wire pin direction wrong");
    a_idle_after_reset: assert property ($rose(rst_b) |-> tx_pin_out && tx_pin_oe && !irq)
        else $error("outputs not idle after reset");
endmodule // uart_ctrl3_data_checker

bind uart_ctrl3_data uart_ctrl3_data_checker chk (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .irq(irq), .tx_pin_in(tx_pin_in), .tx_pin_out(tx_pin_out), .tx_pin_oe(tx_pin_oe), .rx_pin(rx_pin),
    .parity_error_in(parity_error_in));

// file: remote_serial_dev.sv
`timescale 1ns/1ps
`include "uart_slice_map.vh"
module remote_serial_dev
(
    input wire clk,
    input wire line_in,
    output reg line_out
);
    reg nine = 1'b0;
    reg [8:0] got = 9'h000;
    reg stop_seen = 1'b0;
    integer frames = 0;
    integer i;
    initial line_out = 1'b1;

    // Sends one frame, start bit first, data LSB first; a bad stop forces a framing fault.
    // A glitch inverts the second half of the first data bit, which the receiver must flag as noise.
    task send(input [8:0] w, input bad_stop, input glitch);
        reg [10:0] f;
        integer k;
        begin
            f = nine ? {~bad_stop, w, 1'b0} : {1'b1, ~bad_stop, w[7:0], 1'b0};
            @(posedge clk);
            for (k = 0; k < (nine ? 11 : 10); k = k + 1)
            begin
                line_out <= f[k];
                repeat (60) @(posedge clk);
                if (glitch && k == 1)
                begin
                    line_out <= ~f[k];
                end
                repeat (`BIT_CYCLES - 60) @(posedge clk);
            end
            line_out <= 1'b1;
        end
    endtask

    // Samples mid-bit after each start edge; idle is the high mark level.
    always
    begin
        @(negedge line_in);
        got = 9'h000;
        repeat (`BIT_CYCLES / 2) @(posedge clk);
        for (i = 0; i < (nine ? 9 : 8); i = i + 1)
        begin
            repeat (`BIT_CYCLES) @(posedge clk);
            got[i] = line_in;
        end
        repeat (`BIT_CYCLES) @(posedge clk);
        stop_seen = line_in;
        frames = frames + 1;
    end
endmodule // remote_serial_dev

// file: uart_ctrl3_and_data_port_test.sv
`timescale 1ns/1ps
`include "uart_slice_map.vh"
module uart_ctrl3_and_data_port_test;
    reg clk = 1'b0;
    reg rst_b = 1'b0;
    reg psel = 1'b0;
    reg penable = 1'b0;
    reg pwrite = 1'b0;
    reg parity_error_in = 1'b0;
    reg [11:0] paddr = 12'h000;
    reg [31:0] pwdata = 32'h0;
    wire [31:0] prdata;
    wire pready, pslverr, irq, tx_pin_out, tx_pin_oe, rx_pin, tx_wire;
    integer bad_count = 0;
    integer num_checks = 0;
    integer k;
    reg [31:0] rd;
    reg err;
    reg [7:0] b;

    always #4 clk = ~clk;
    // The transmit wire has a pull-up, so a released pin reads high.
    assign tx_wire = tx_pin_oe ? tx_pin_out : 1'b1;

    uart_ctrl3_data dut (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
        .tx_pin_in(tx_wire), .tx_pin_out(tx_pin_out), .tx_pin_oe(tx_pin_oe), .rx_pin(rx_pin),
        .parity_error_in(parity_error_in));
    remote_serial_dev peer (.clk(clk), .line_in(tx_wire), .line_out(rx_pin));

    // ****************************************
    // Shared tasks.
    // ****************************************
    task print_verdict;
        begin
            if (bad_count == 0 && num_checks > 0)
                $display("TEST PASSED");
            else
                $display("TEST FAILED");
            $finish;
        end
    endtask

    task check(input string what, input [31:0] seen, input [31:0] expct);
        begin
            num_checks = num_checks + 1;
            if (seen !== expct)
            begin
                bad_count = bad_count + 1;
                $display("[FAIL] %s expected %h seen %h", what, expct, seen);
            end
        end
    endtask

    // Bus cycle; the wait on pready is bounded, and outputs settle before return.
    task apb(input w, input [11:0] a, input [31:0] d);
        integer n;
        begin
            @(posedge clk);
            psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
            @(posedge clk);
            penable <= 1'b1;
            n = 0;
            @(posedge clk);
            while (pready !== 1'b1 && n < 20)
            begin
                n = n + 1;
                @(posedge clk);
            end
            check("pready wait", n < 20, 1);
            rd = prdata;
            err = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
            @(negedge clk);
        end
    endtask

    task wait_frames(input integer n);
        integer c;
        begin
            c = 0;
            while (peer.frames < n && c < 3000)
            begin
                @(posedge clk);
                c = c + 1;
            end
            check("frame count", peer.frames, n);
        end
    endtask

    // ****************************************
    // Scenarios.
    // ****************************************
    task t_reset;
        begin
            apb(0, `ADDR_CTRL3, 0);
            check("ctrl3 reset", rd, 32'h0);
            check("idle line", tx_pin_out, 1);
            check("irq idle", irq, 0);
            apb(0, 12'h040, 0);
            check("unmapped err", err, 1);
            check("unmapped data", rd, 0);
        end
    endtask

    // Ninth bit set once, then reused; last frame in eight-bit mode drops it.
    task t_tx;
        begin
            for (k = 0; k < 3; k = k + 1)
            begin
                b = (k == 0) ? 8'hA5 : (k == 1) ? 8'h3C : 8'h5A;
                apb(1, `ADDR_MODE, k < 2);
                peer.nine = (k < 2);
                if (k == 0) apb(1, `ADDR_CTRL3, 32'h40);
                apb(1, `ADDR_DATA, {24'h0, b});
                wait_frames(k + 1);
                check("tx word", peer.got, {k < 2, b});
                check("tx stop", peer.stop_seen, 1);
            end
        end
    endtask

    task t_rx;
        begin
            for (k = 0; k < 2; k = k + 1)
            begin
                apb(1, `ADDR_MODE, k == 0);
                peer.nine = (k == 0);
                peer.send(9'h1C3, 1'b0, 1'b0);
                apb(0, `ADDR_CTRL3, 0);
                check("ninth rx", rd, (k == 0) ? 32'hC0 : 32'h40);
                apb(0, `ADDR_DATA, 0);
                check("rx byte", rd, 32'hC3);
            end
        end
    endtask

    // Rows: parity, framing, overrun, noise, then parity with its enable off.
    // An enabled flag keeps re-arming its status bit, so irq only drops once the flags are cleared.
    task t_irq;
        reg [3:0] ex;
        begin
            apb(1, `ADDR_IRQ_MASK, 32'h0F);
            for (k = 0; k < 5; k = k + 1)
            begin
                ex = (k == 0) ? 4'h1 : (k == 1) ? 4'h2 : (k == 2) ? 4'h8 : (k == 3) ? 4'h4 : 4'h0;
                apb(1, `ADDR_CTRL3, (k == 4) ? 32'h00 : 32'h0F);
                apb(0, `ADDR_IRQ_STAT, 0);
                @(posedge clk);
                parity_error_in <= (k == 0 || k == 4);
                repeat ((k == 2) ? 2 : 1) peer.send(9'h055, k == 1, k == 3);
                repeat (4) @(posedge clk);
                parity_error_in <= 1'b0;
                @(negedge clk);
                check("irq line", irq, ex != 0);
                apb(0, `ADDR_IRQ_STAT, 0);
                check("irq cause", rd[3:0], ex);
                check("irq held", irq, ex != 0);
                apb(0, `ADDR_STATUS, 0);
                apb(0, `ADDR_DATA, 0);
                apb(0, `ADDR_STATUS, 0);
                check("flags cleared", rd[4:0], 0);
                apb(0, `ADDR_IRQ_STAT, 0);
                check("irq cleared", irq, 0);
            end
        end
    endtask

    // Internal loopback first, then inversion and the single-wire direction.
    task t_pins;
        begin
            apb(1, `ADDR_MODE, 32'h02);
            apb(1, `ADDR_DATA, 32'h96);
            repeat (1300) @(posedge clk);
            apb(0, `ADDR_DATA, 0);
            check("loop byte", rd, 32'h96);
            apb(1, `ADDR_MODE, 0);
            apb(1, `ADDR_CTRL3, 32'h10);
            check("inverted idle", tx_pin_out, 0);
            apb(1, `ADDR_MODE, 32'h06);
            apb(1, `ADDR_CTRL3, 32'h00);
            check("single wire input", tx_pin_oe, 0);
            apb(1, `ADDR_CTRL3, 32'h20);
            check("single wire output", tx_pin_oe, 1);
        end
    endtask

    // Main sequence after a five-cycle reset.
    initial
    begin
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        t_reset;
        t_tx;
        t_rx;
        t_irq;
        t_pins;
        print_verdict;
    end

    // Watchdog well beyond the roughly 15600 cycles the run needs.
    initial
    begin
        repeat (60000) @(posedge clk);
        bad_count = bad_count + 1;
        print_verdict;
    end
endmodule // uart_ctrl3_and_data_port_test
